// ===== bench/osc_source_model.sv
// Behavioural crystal or square-wave source feeding the clock monitor.
// Assumes run_i follows the oscillator enable of the controller.
`timescale 1ns/1ps
module osc_source_model #(
	parameter int STARTUP = 64
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic run_i,
	input wire logic square_i,
	input wire logic fail_i,
	// Monitor
	output logic clk_ok_o
);
	int cnt;
	// A crystal stopped by STOP needs a start-up time before it is good
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			cnt <= 0;
		else if (fail_i || !(run_i || square_i))
			cnt <= 0;
		else if (cnt < STARTUP)
			cnt <= cnt + 1;
	end
	assign clk_ok_o = (cnt >= STARTUP);
endmodule : osc_source_model

// ===== bench/tb_stop_exit_limp_home_control.sv
// Testbench for the stop-exit and limp-home controller.
// Assumes the bus master may wait any number of cycles for an answer.
`timescale 1ns/1ps
module tb_stop_exit_limp_home_control;
	import stop_exit_pkg::*;
	logic clk = 0, rst = 1, sx = 0, square = 0, fail = 0, clk_ok;
	logic [4:0] wk = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic STOP_O, OSC_RUN_O, CM_RESET_O, CM_FORCED_O, VCO_CLK_SEL_O;
	logic PLL_BUS_SEL_O, MODULE_CLK_SEL_O, VCO_RESTART_O;
	logic PLL_RELOCK_O, LIMP_IRQ_O;
	int err_count = 0, compares = 0, cyc = 0, t0;
	always #4 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	stop_exit_limp_home_control stop_exit_limp_home_control_i (
		.SYS_CLK_I(clk), .RST_I(rst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .STOP_EXEC_I(sx),
		.WAKE_IRQ_I(wk[0]), .WAKE_NMI_I(wk[1]), .WAKE_KEY_J_I(wk[2]),
		.WAKE_KEY_H_I(wk[3]), .WAKE_CAN_I(wk[4]),
		.EXT_CLK_OK_I(clk_ok), .STOP_O(STOP_O), .OSC_RUN_O(OSC_RUN_O),
		.CM_RESET_O(CM_RESET_O), .CM_FORCED_O(CM_FORCED_O),
		.VCO_CLK_SEL_O(VCO_CLK_SEL_O), .PLL_BUS_SEL_O(PLL_BUS_SEL_O),
		.MODULE_CLK_SEL_O(MODULE_CLK_SEL_O),
		.VCO_RESTART_O(VCO_RESTART_O), .PLL_RELOCK_O(PLL_RELOCK_O),
		.LIMP_IRQ_O(LIMP_IRQ_O)
	);
	osc_source_model osc_source_model_i (
		.clk_i(clk), .rst_i(rst), .run_i(OSC_RUN_O),
		.square_i(square), .fail_i(fail), .clk_ok_o(clk_ok)
	);
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	task automatic do_reset;
		@(posedge clk) rst <= 1;
		repeat (10) @(posedge clk);
		rst <= 0;
	endtask : do_reset
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		// No cycle count is assumed; only the watchdog ends a wait
		do begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 0;
			if (wready === 1'b1) wvalid <= 0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge clk);
			if (arready === 1'b1) arvalid <= 0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 0;
	endtask : rd
	// Leaves time just after the edge that took the event
	task automatic exec_stop(input logic [31:0] c);
		logic [1:0] r;
		wr(CTRL_OFFSET, c, r);
		@(posedge clk) sx <= 1;
		@(posedge clk) sx <= 0;
		#1;
	endtask : exec_stop
	task automatic wake(input logic [4:0] s);
		@(posedge clk) wk <= s;
		@(posedge clk) wk <= 0;
		#1;
		t0 = cyc;
	endtask : wake
	task automatic wait_low(input bit forced, input int lim);
		int n = 0;
		while (((forced ? CM_FORCED_O : STOP_O) !== 1'b0) && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(n < lim, 1);
	endtask : wait_low
	task automatic stat_is(input logic [1:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(STAT_OFFSET, d, r);
		check(d[1:0], e);
	endtask : stat_is
	task automatic clear_change;
		logic [1:0] r;
		wr(STAT_OFFSET, 32'h2, r);
		@(posedge clk);
		#1;
		check(LIMP_IRQ_O, 0);
		stat_is(2'h0);
	endtask : clear_change
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_values;
		logic [31:0] d;
		logic [1:0] r;
		rd(CTRL_OFFSET, d, r);
		check(d, 32'h002);
		rd(DIV_OFFSET, d, r);
		check(d, 0);
		rd(STAT_OFFSET, d, r);
		check(d, 0);
		rd(8'h0c, d, r);
		check(r, RESP_SLVERR);
		check(d, 0);
		wr(8'h0c, 0, r);
		check(r, RESP_SLVERR);
		check(OSC_RUN_O, 1);
	endtask : t_reset_values
	task automatic t_monitor_reset;
		logic [8:0] c[3] = '{9'h003, 9'h005, 9'h013};
		for (int i = 0; i < 3; i++) begin
			exec_stop({23'h0, c[i]});
			check(CM_RESET_O, 1);
			do_reset;
		end
	endtask : t_monitor_reset
	task automatic t_delay_good;
		logic [1:0] r;
		wr(DIV_OFFSET, 1, r);
		// Crystal in use, so the exit delay is on
		exec_stop(32'h1ca);
		check(CM_RESET_O, 0);
		check({STOP_O, OSC_RUN_O}, 2'b10);
		wake(5'h01);
		check(CM_FORCED_O, 1);
		check({VCO_CLK_SEL_O, PLL_BUS_SEL_O, MODULE_CLK_SEL_O}, 3'h6);
		wait_low(0, 20000);
		check(cyc - t0 >= 8192 && cyc - t0 <= 8210, 1);
		check(CM_FORCED_O, 0);
		check(MODULE_CLK_SEL_O, 1);
		stat_is(2'h0);
		wr(DIV_OFFSET, 0, r);
	endtask : t_delay_good
	task automatic t_delay_fail;
		@(posedge clk) fail <= 1;
		exec_stop(32'h1f8);
		check(OSC_RUN_O, 1);
		wake(5'h02);
		check(CM_FORCED_O, 1);
		check({PLL_BUS_SEL_O, MODULE_CLK_SEL_O}, 2'b10);
		wait_low(0, 5000);
		check(cyc - t0 >= 4096 && cyc - t0 <= 4110, 1);
		t0 = cyc;
		check(CM_FORCED_O, 1);
		check(LIMP_IRQ_O, 1);
		stat_is(2'h3);
		@(posedge clk) fail <= 0;
		wait_low(1, 9000);
		check(cyc - t0 >= 8188 && cyc - t0 <= 8200, 1);
		check(PLL_RELOCK_O, 1);
		check(MODULE_CLK_SEL_O, 1);
		stat_is(2'h2);
		clear_change;
	endtask : t_delay_fail
	task automatic t_fast;
		@(posedge clk) square <= 1;
		exec_stop(32'h002);
		wake(5'h04);
		check({STOP_O, CM_FORCED_O}, 2'b00);
		stat_is(2'h0);
		@(posedge clk) square <= 0;
		exec_stop(32'h002);
		wake(5'h08);
		check({STOP_O, CM_FORCED_O}, 2'b01);
		check(LIMP_IRQ_O, 0);
		stat_is(2'h3);
		wait_low(1, 9000);
		clear_change;
	endtask : t_fast
	task automatic t_pseudo_fast;
		logic [1:0] r;
		@(posedge clk) fail <= 1;
		exec_stop(32'h152);
		check(OSC_RUN_O, 1);
		wake(5'h10);
		check({STOP_O, VCO_RESTART_O}, 2'b01);
		// Software drops the PLL select so the PLL stays off after exit
		wr(CTRL_OFFSET, 32'h112, r);
		check(PLL_BUS_SEL_O, 1);
		@(posedge clk) fail <= 0;
		wait_low(1, 9000);
		check(PLL_BUS_SEL_O, 0);
		check(PLL_RELOCK_O, 0);
		clear_change;
	endtask : t_pseudo_fast
	task automatic t_no_limp;
		exec_stop(32'h019);
		wake(5'h01);
		check(VCO_CLK_SEL_O, 0);
		wait_low(0, 5000);
		check(cyc - t0 >= 4096 && cyc - t0 <= 4110, 1);
		// Odd passes are pseudo-stop, each wake source used twice
		for (int i = 0; i < 10; i++) begin
			exec_stop(i[0] ? 32'h011 : 32'h001);
			check({STOP_O, OSC_RUN_O}, {1'b1, i[0]});
			wake(5'h01 << (i / 2));
			wait_low(0, 100);
			check(cyc - t0 <= (i[0] ? 20 : 0), 1);
			check(cyc - t0 >= (i[0] ? 16 : 0), 1);
		end
	endtask : t_no_limp
	initial begin
		// About 35000 cycles of tests, with margin
		repeat (60000) @(posedge clk);
		err_count++;
		tally_and_finish;
	end
	initial begin
		do_reset;
		t_reset_values;
		t_monitor_reset;
		t_delay_good;
		t_delay_fail;
		t_fast;
		t_pseudo_fast;
		t_no_limp;
		tally_and_finish;
	end
endmodule : tb_stop_exit_limp_home_control

// ===== inc/stop_exit_pkg.sv
// Constants and carrier types for the stop-exit and limp-home controller.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package stop_exit_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] DIV_OFFSET = 8'h04;
	localparam logic [7:0] STAT_OFFSET = 8'h08;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_W = 9;
	localparam int DIV_W = 4;
	localparam int STAT_ACTIVE_BIT = 0;
	localparam int STAT_CHANGE_BIT = 1;
	localparam int STAT_STATE_LSB = 2;
	localparam int STAT_PSEUDO_BIT = 4;

	// ----------------------------------------------------------------
	// Counter timing
	// ----------------------------------------------------------------
	localparam int CNT_W = 13;
	localparam int MID_COUNT = 4096;
	localparam int SHORT_COUNT = 16;

	// ----------------------------------------------------------------
	// Bus responses
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic pll_bw_selfadjust;
		logic module_clock_sel;
		logic pll_bus_clock_sel;
		logic limp_irq_en;
		logic low_power_osc_stop;
		logic stop_exit_delay_en;
		logic forced_clock_monitor_en;
		logic clock_monitor_en;
		logic limp_disable;
	} ctrl_type;

	// Any reset turns the clock monitor on and leaves limp-home enabled
	localparam ctrl_type CTRL_RESET = 9'h002;
	localparam logic [DIV_W-1:0] DIV_RESET = 4'h0;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_STOP,
		ST_DELAY,
		ST_LIMP
	} state_type;

endpackage : stop_exit_pkg

// ===== src/clock_tick_divider.sv
// Slow-mode divider: one-cycle counter_clock enable pulses.
// Assumes the division ratio only changes while the block is idle.
`timescale 1ns/1ps
module clock_tick_divider #(
	parameter int DIV_W = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic [DIV_W-1:0] div_i,
	// Enable pulse
	output logic tick_o
);
	logic [DIV_W-1:0] cnt_q, cnt_d;
	logic tick_d;

	always_comb begin
		tick_d = (cnt_q >= div_i);
		cnt_d = tick_d ? '0 : cnt_q + 1'b1;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= '0;
			tick_o <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_o <= tick_d;
		end
	end

endmodule : clock_tick_divider

// ===== src/ripple_stage_counter.sv
// Free-running 13-stage counter advanced by counter_clock enables.
// Assumes clr_i and tick_i are one-cycle pulses from the controller.
`timescale 1ns/1ps
module ripple_stage_counter
	import stop_exit_pkg::*;
#(
	parameter int MID = MID_COUNT,
	parameter int SHORT = SHORT_COUNT
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic clr_i,
	input wire logic tick_i,
	// Count events
	output logic mid_o,
	output logic short_o
);
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic mid_d, short_d;

	always_comb begin
		cnt_d = cnt_q;
		mid_d = 1'b0;
		short_d = 1'b0;
		if (clr_i) begin
			cnt_d = '0;
		end else if (tick_i) begin
			// Wraps at 8192, so the mid-count recurs every 8192 ticks
			cnt_d = cnt_q + 1'b1;
			mid_d = (cnt_q == CNT_W'(MID - 1));
			short_d = (cnt_q == CNT_W'(SHORT - 1));
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= '0;
			mid_o <= 1'b0;
			short_o <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			mid_o <= mid_d;
			short_o <= short_d;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_mid_at_count;
		mid_o |-> cnt_q == CNT_W'(MID);
	endproperty
	a_mid_at_count: assert property (p_mid_at_count)
		else $error("mid pulse away from mid-count");

endmodule : ripple_stage_counter

// ===== src/stop_exit_limp_home_control.sv
// Stop and pseudo-stop exit controller with limp-home clock fallback.
// Assumes STOP_EXEC_I is a one-cycle pulse and the wake and clock
// monitor inputs are synchronous to SYS_CLK_I.
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module stop_exit_limp_home_control
	import stop_exit_pkg::*;
(
	// Clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	// AXI4-Lite write channels
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// AXI4-Lite read channels
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Core and wake-up events
	input wire logic STOP_EXEC_I,
	input wire logic WAKE_IRQ_I,
	input wire logic WAKE_NMI_I,
	input wire logic WAKE_KEY_J_I,
	input wire logic WAKE_KEY_H_I,
	input wire logic WAKE_CAN_I,
	input wire logic EXT_CLK_OK_I,
	// Clock control
	output logic STOP_O,
	output logic OSC_RUN_O,
	output logic CM_RESET_O,
	output logic CM_FORCED_O,
	output logic VCO_CLK_SEL_O,
	output logic PLL_BUS_SEL_O,
	output logic MODULE_CLK_SEL_O,
	output logic VCO_RESTART_O,
	output logic PLL_RELOCK_O,
	output logic LIMP_IRQ_O
);
	import stop_exit_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	ctrl_type ctrl_q, ctrl_d;
	logic [DIV_W-1:0] div_q, div_d;
	state_type st_q, st_d;
	logic pseudo_q, pseudo_d;
	logic dl_limp_q, dl_limp_d;
	logic dl_short_q, dl_short_d;
	logic active_q, active_d;
	logic change_q, change_d;
	logic chg_set, chg_clr;
	logic cnt_clr;
	logic tick, mid_hit, short_hit;
	logic wake, mon_on, limp_mode, relock_cond;
	logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
	logic [1:0] bresp_d, rresp_d;
	logic [31:0] rdata_d;
	logic stop_d, osc_d, cmrst_d, cmf_d, vco_d, bus_d, mod_d;
	logic vrst_d, relock_d, irq_d;

	// ----------------------------------------------------------------
	// Counter clock and 13-stage counter
	// ----------------------------------------------------------------
	clock_tick_divider #(.DIV_W(DIV_W)) u_div (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.div_i(div_q),
		.tick_o(tick)
	);

	ripple_stage_counter #(.MID(MID_COUNT), .SHORT(SHORT_COUNT)) u_cnt (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.clr_i(cnt_clr),
		.tick_i(tick),
		.mid_o(mid_hit),
		.short_o(short_hit)
	);

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	// Write is taken only when address and data are both present, so a
	// single cycle decides it and the order of arrival does not matter.
	always_comb begin
		ctrl_d = ctrl_q;
		div_d = div_q;
		chg_clr = 1'b0;
		awready_d = 1'b0;
		wready_d = 1'b0;
		bvalid_d = S_AXI_BVALID & ~S_AXI_BREADY;
		bresp_d = S_AXI_BRESP;
		arready_d = 1'b0;
		rvalid_d = S_AXI_RVALID & ~S_AXI_RREADY;
		rresp_d = S_AXI_RRESP;
		rdata_d = S_AXI_RDATA;
		if (S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_AWREADY &&
				!S_AXI_BVALID) begin
			awready_d = 1'b1;
			wready_d = 1'b1;
			bvalid_d = 1'b1;
			bresp_d = RESP_OKAY;
			case (S_AXI_AWADDR)
			CTRL_OFFSET: begin
				if (S_AXI_WSTRB[0])
					ctrl_d[7:0] = S_AXI_WDATA[7:0];
				if (S_AXI_WSTRB[1])
					ctrl_d[8] = S_AXI_WDATA[8];
			end
			DIV_OFFSET: begin
				if (S_AXI_WSTRB[0])
					div_d = S_AXI_WDATA[DIV_W-1:0];
			end
			STAT_OFFSET: begin
				chg_clr = S_AXI_WSTRB[0] & S_AXI_WDATA[STAT_CHANGE_BIT];
			end
			default: bresp_d = RESP_SLVERR;
			endcase
		end
		if (S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID) begin
			arready_d = 1'b1;
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			rdata_d = '0;
			case (S_AXI_ARADDR)
			CTRL_OFFSET: rdata_d[CTRL_W-1:0] = ctrl_q;
			DIV_OFFSET: rdata_d[DIV_W-1:0] = div_q;
			STAT_OFFSET: begin
				rdata_d[STAT_ACTIVE_BIT] = active_q;
				rdata_d[STAT_CHANGE_BIT] = change_q;
				rdata_d[STAT_STATE_LSB +: 2] = st_q;
				rdata_d[STAT_PSEUDO_BIT] = pseudo_q;
			end
			default: rresp_d = RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ctrl_q <= CTRL_RESET;
			div_q <= DIV_RESET;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RRESP <= RESP_OKAY;
			S_AXI_RDATA <= '0;
		end else begin
			ctrl_q <= ctrl_d;
			div_q <= div_d;
			S_AXI_AWREADY <= awready_d;
			S_AXI_WREADY <= wready_d;
			S_AXI_BVALID <= bvalid_d;
			S_AXI_BRESP <= bresp_d;
			S_AXI_ARREADY <= arready_d;
			S_AXI_RVALID <= rvalid_d;
			S_AXI_RRESP <= rresp_d;
			S_AXI_RDATA <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Stop and limp-home sequencing
	// ----------------------------------------------------------------
	assign wake = WAKE_IRQ_I | WAKE_NMI_I | WAKE_KEY_J_I |
		WAKE_KEY_H_I | WAKE_CAN_I;
	assign mon_on = ctrl_q.clock_monitor_en |
		ctrl_q.forced_clock_monitor_en;
	assign relock_cond = ctrl_q.pll_bw_selfadjust &
		ctrl_q.pll_bus_clock_sel;

	always_comb begin
		st_d = st_q;
		pseudo_d = pseudo_q;
		dl_limp_d = dl_limp_q;
		dl_short_d = dl_short_q;
		active_d = active_q;
		chg_set = 1'b0;
		cnt_clr = 1'b0;
		cmrst_d = 1'b0;
		vrst_d = 1'b0;
		relock_d = 1'b0;
		case (st_q)
		ST_RUN: begin
			if (STOP_EXEC_I) begin
				if (ctrl_q.limp_disable && mon_on) begin
					cmrst_d = 1'b1;
				end else begin
					// Monitor masked here, so no failure is raised
					st_d = ST_STOP;
					pseudo_d = ctrl_q.low_power_osc_stop;
				end
			end
		end
		ST_STOP: begin
			if (wake) begin
				cnt_clr = 1'b1;
				if (!ctrl_q.limp_disable) begin
					if (ctrl_q.stop_exit_delay_en) begin
						st_d = ST_DELAY;
						dl_limp_d = 1'b1;
						dl_short_d = 1'b0;
					end else if (EXT_CLK_OK_I) begin
						st_d = ST_RUN;
					end else begin
						st_d = ST_LIMP;
						active_d = 1'b1;
						chg_set = 1'b1;
						vrst_d = pseudo_q;
					end
				end else if (ctrl_q.stop_exit_delay_en || pseudo_q) begin
					st_d = ST_DELAY;
					dl_limp_d = 1'b0;
					dl_short_d = ~ctrl_q.stop_exit_delay_en;
				end else begin
					st_d = ST_RUN;
				end
			end
		end
		ST_DELAY: begin
			if (dl_short_q ? short_hit : mid_hit) begin
				if (!dl_limp_q || EXT_CLK_OK_I) begin
					st_d = ST_RUN;
					relock_d = dl_limp_q & relock_cond;
				end else begin
					st_d = ST_LIMP;
					active_d = 1'b1;
					chg_set = 1'b1;
				end
			end
		end
		ST_LIMP: begin
			// Only the mid-count samples the monitor
			if (mid_hit && EXT_CLK_OK_I) begin
				st_d = ST_RUN;
				active_d = 1'b0;
				chg_set = 1'b1;
				relock_d = relock_cond;
			end
		end
		default: st_d = ST_RUN;
		endcase
		// A new change event beats a software clear in the same cycle
		change_d = chg_set | (change_q & ~chg_clr);
	end

	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			st_q <= ST_RUN;
			pseudo_q <= 1'b0;
			dl_limp_q <= 1'b0;
			dl_short_q <= 1'b0;
			active_q <= 1'b0;
			change_q <= 1'b0;
		end else begin
			st_q <= st_d;
			pseudo_q <= pseudo_d;
			dl_limp_q <= dl_limp_d;
			dl_short_q <= dl_short_d;
			active_q <= active_d;
			change_q <= change_d;
		end
	end

	// ----------------------------------------------------------------
	// Clock control outputs
	// ----------------------------------------------------------------
	// Selects are forced in limp-home and in a limp-enabled exit delay; the software copies in
	// ctrl_q are never overwritten, so exit restores them, including any
	// change software made during limp-home.
	always_comb begin
		limp_mode = (st_d == ST_LIMP) || (st_d == ST_DELAY && dl_limp_d);
		stop_d = (st_d == ST_STOP) || (st_d == ST_DELAY);
		osc_d = !(st_d == ST_STOP && !pseudo_d);
		cmf_d = limp_mode;
		vco_d = limp_mode;
		bus_d = limp_mode | ctrl_q.pll_bus_clock_sel;
		mod_d = !limp_mode & ctrl_q.module_clock_sel;
		irq_d = change_d & ctrl_q.limp_irq_en;
	end

	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			STOP_O <= 1'b0;
			OSC_RUN_O <= 1'b1;
			CM_RESET_O <= 1'b0;
			CM_FORCED_O <= 1'b0;
			VCO_CLK_SEL_O <= 1'b0;
			PLL_BUS_SEL_O <= 1'b0;
			MODULE_CLK_SEL_O <= 1'b0;
			VCO_RESTART_O <= 1'b0;
			PLL_RELOCK_O <= 1'b0;
			LIMP_IRQ_O <= 1'b0;
		end else begin
			STOP_O <= stop_d;
			OSC_RUN_O <= osc_d;
			CM_RESET_O <= cmrst_d;
			CM_FORCED_O <= cmf_d;
			VCO_CLK_SEL_O <= vco_d;
			PLL_BUS_SEL_O <= bus_d;
			MODULE_CLK_SEL_O <= mod_d;
			VCO_RESTART_O <= vrst_d;
			PLL_RELOCK_O <= relock_d;
			LIMP_IRQ_O <= irq_d;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (RST_I);

	sequence s_delay_fail;
		st_q == ST_DELAY && !dl_short_q && dl_limp_q && mid_hit &&
			!EXT_CLK_OK_I;
	endsequence
	sequence s_in_limp_flagged;
		st_q == ST_LIMP && active_q && change_q;
	endsequence

	property p_cm_reset;
		st_q == ST_RUN && STOP_EXEC_I && ctrl_q.limp_disable && mon_on
			|=> CM_RESET_O && st_q == ST_RUN;
	endproperty
	a_cm_reset: assert property (p_cm_reset)
		else $error("stop with monitor on did not reset");

	property p_stop_masked;
		st_q == ST_RUN && STOP_EXEC_I && !ctrl_q.limp_disable
			|=> st_q == ST_STOP && !CM_RESET_O;
	endproperty
	a_stop_masked: assert property (p_stop_masked)
		else $error("masked stop did not enter stop");

	property p_limp_forced;
		st_q == ST_LIMP |-> CM_FORCED_O && VCO_CLK_SEL_O &&
			PLL_BUS_SEL_O && !MODULE_CLK_SEL_O;
	endproperty
	a_limp_forced: assert property (p_limp_forced)
		else $error("limp-home clocks not forced");

	property p_delay_good;
		st_q == ST_DELAY && !dl_short_q && mid_hit && EXT_CLK_OK_I
			|=> st_q == ST_RUN && !STOP_O ##1 !VCO_CLK_SEL_O;
	endproperty
	a_delay_good: assert property (p_delay_good)
		else $error("good clock at delay end not resumed");

	property p_delay_fail;
		s_delay_fail |=> s_in_limp_flagged ##1 !STOP_O;
	endproperty
	a_delay_fail: assert property (p_delay_fail)
		else $error("failed clock did not enter flagged limp-home");

	property p_limp_exit;
		st_q == ST_LIMP && mid_hit && EXT_CLK_OK_I
			|=> st_q == ST_RUN && !active_q && change_q;
	endproperty
	a_limp_exit: assert property (p_limp_exit)
		else $error("limp-home exit flags wrong");

	property p_limp_irq;
		change_q && ctrl_q.limp_irq_en && !chg_clr |=> LIMP_IRQ_O;
	endproperty
	a_limp_irq: assert property (p_limp_irq)
		else $error("limp-home interrupt not requested");

	property p_square_fast;
		st_q == ST_STOP && wake && !ctrl_q.limp_disable &&
			!ctrl_q.stop_exit_delay_en && EXT_CLK_OK_I
			|=> st_q == ST_RUN && !active_q [*2];
	endproperty
	a_square_fast: assert property (p_square_fast)
		else $error("square-wave fast exit set active flag");

	property p_short_delay;
		st_q == ST_STOP && wake && ctrl_q.limp_disable &&
			!ctrl_q.stop_exit_delay_en && pseudo_q
			|=> st_q == ST_DELAY && dl_short_q && !dl_limp_q;
	endproperty
	a_short_delay: assert property (p_short_delay)
		else $error("short pseudo-stop delay not chosen");

	property p_pseudo_osc;
		st_q == ST_STOP && pseudo_q |-> OSC_RUN_O;
	endproperty
	a_pseudo_osc: assert property (p_pseudo_osc)
		else $error("oscillator stopped in pseudo-stop");

endmodule : stop_exit_limp_home_control
